// File: hw/epa_accumulator.sv
`include "epa_defs.svh"

// Overview of operation
// - A read-only signed speed in tenths of rpm, clamped to +/-40000 rpm, is IIR filtered.
// - The readable revolution count is 16-bit unsigned and refreshed every 4 ms.
// - Position is 48 bits of 1/2^32 revolution: revolutions, coarse, fine.
// - The feedback position output refreshes every 250 us, the coarse reading every 4 ms.
// - A full revolution crossing counts the revolutions up or down with 16-bit roll-over.
// - With an absolute source the accumulator loads the absolute position once after reset.
// - In linear mode one revolution is the travel over pole_count/2 pole pitches.
// - Changing the encoder type clears revolutions, coarse and fine position.
// - The marker is active on its rising edge going forward, falling edge in reverse.
// - A marker event resets position and sets the flag unless inhibited, then only flags.
// - A marker position reset clears both coarse and fine position.
// - The marker flag is set by hardware or by a software write of 1, and cleared by a software write of 0.
// - Marker handling works only for the incremental, their servo and sine-cosine servo types.
// - Outside linear mode, a turns mask of zero holds the revolution count at zero.
// - Outside linear mode a turns mask n wraps the count after 2^n-1, with n above 16 taken as 16.
module epa_accumulator #(
    parameter int SAMPLE_CYCLES = `EPA_SAMPLE_CYCLES,
    parameter int DISPLAY_SAMPLES = `EPA_DISPLAY_SAMPLES,
    parameter int FILTER_SHIFT = `EPA_FILTER_SHIFT
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic enc_delta_valid,
    input wire logic [31:0] enc_delta,
    input wire logic enc_abs_valid,
    input wire logic [47:0] enc_abs_position,
    input wire logic marker_in,
    output logic [31:0] feedback_position,
    output logic irq
);

    localparam logic [63:0] RPM_SCALE =
        (`EPA_NS_PER_MIN * `EPA_SPEED_SCALE) / (SAMPLE_CYCLES * `EPA_CLK_PERIOD_NS);

    function automatic logic [15:0] epa_turns_mask(input logic [7:0] bits);
        logic [16:0] weight;
        weight = 17'h0_0001 << bits[4:0];
        epa_turns_mask = (bits >= `EPA_TURNS_MAX) ? 16'hFFFF : 16'(weight - 17'h0_0001);
    endfunction : epa_turns_mask

    function automatic logic epa_marker_type(input logic [3:0] t);
        epa_marker_type = (t <= epa_pkg::epa_forward_reverse_servo)
            || (t == epa_pkg::epa_sine_cosine_servo);
    endfunction : epa_marker_type

    function automatic logic epa_absolute_type(input logic [3:0] t);
        epa_absolute_type = (t == epa_pkg::epa_absolute_comms)
            || (t == epa_pkg::epa_sine_cosine_absolute);
    endfunction : epa_absolute_type

    // software registers
    logic marker_reset_inhibit;
    logic marker_seen_flag;
    logic [7:0] turns_mask_bits;
    logic [3:0] encoder_type_select;
    logic linear_select;
    logic [7:0] motor_pole_count;
    logic [`EPA_IRQ_W-1:0] irq_status;
    logic [`EPA_IRQ_W-1:0] irq_enable;

    // readable copies
    logic signed [31:0] shaft_speed_rpm;
    logic [15:0] revolution_count;
    logic [15:0] coarse_position;
    logic [15:0] fine_position;

    // live state
    logic [15:0] rev_acc;
    logic [31:0] sub_acc;
    logic [7:0] pitch_cnt;
    logic abs_pending;
    logic dir_reverse;
    logic marker_prev;
    logic [31:0] sample_cnt;
    logic [7:0] disp_cnt;
    logic [31:0] window_sum;
    logic signed [31:0] speed_filt;

    // bus decode
    wire wr_fire = avs_write && !avs_waitrequest;
    wire wr_low = wr_fire && avs_byteenable[0];
    wire sel_speed = avs_address == `EPA_REG_SPEED;
    wire sel_revs = avs_address == `EPA_REG_REVS;
    wire sel_coarse = avs_address == `EPA_REG_COARSE;
    wire sel_fine = avs_address == `EPA_REG_FINE;
    wire sel_inhibit = avs_address == `EPA_REG_INHIBIT;
    wire sel_flag = avs_address == `EPA_REG_FLAG;
    wire sel_turns = avs_address == `EPA_REG_TURNS;
    wire sel_type = avs_address == `EPA_REG_TYPE;
    wire sel_linear = avs_address == `EPA_REG_LINEAR;
    wire sel_poles = avs_address == `EPA_REG_POLES;
    wire sel_status = avs_address == `EPA_REG_IRQ_STATUS;
    wire sel_clear = avs_address == `EPA_REG_IRQ_CLEAR;
    wire sel_enable = avs_address == `EPA_REG_IRQ_ENABLE;
    wire sel_feedback = avs_address == `EPA_REG_FEEDBACK;

    // unmapped and write-only offsets read as zero
    wire [31:0] rd_value = ({32{sel_speed}} & shaft_speed_rpm)
        | ({32{sel_revs}} & {16'h0000, revolution_count})
        | ({32{sel_coarse}} & {16'h0000, coarse_position})
        | ({32{sel_fine}} & {16'h0000, fine_position})
        | ({32{sel_inhibit}} & {31'h0000_0000, marker_reset_inhibit})
        | ({32{sel_flag}} & {31'h0000_0000, marker_seen_flag})
        | ({32{sel_turns}} & {24'h00_0000, turns_mask_bits})
        | ({32{sel_type}} & {28'h000_0000, encoder_type_select})
        | ({32{sel_linear}} & {31'h0000_0000, linear_select})
        | ({32{sel_poles}} & {24'h00_0000, motor_pole_count})
        | ({32{sel_status}} & {29'h0000_0000, irq_status})
        | ({32{sel_enable}} & {29'h0000_0000, irq_enable})
        | ({32{sel_feedback}} & feedback_position);

    // one wait state per access; read data is captured when the request is seen
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? rd_value : 32'h0000_0000;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    wire type_change = wr_low && sel_type && (avs_writedata[3:0] != encoder_type_select);
    wire flag_wr = wr_low && sel_flag;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            marker_reset_inhibit <= 1'b0;
            turns_mask_bits <= `EPA_RST_TURNS;
            encoder_type_select <= epa_pkg::epa_quadrature_incremental;
            linear_select <= 1'b0;
            motor_pole_count <= `EPA_RST_POLES;
            irq_enable <= '0;
        end else if (wr_low) begin
            if (sel_inhibit) marker_reset_inhibit <= avs_writedata[0];
            if (sel_turns) turns_mask_bits <= avs_writedata[7:0];
            if (sel_type) encoder_type_select <= avs_writedata[3:0];
            if (sel_linear) linear_select <= avs_writedata[0];
            if (sel_poles) motor_pole_count <= avs_writedata[7:0];
            if (sel_enable) irq_enable <= avs_writedata[`EPA_IRQ_W-1:0];
        end
    end

    // sample and display timebase
    wire sample_tick = sample_cnt == 32'(SAMPLE_CYCLES - 1);
    wire disp_tick = sample_tick && (disp_cnt == 8'(DISPLAY_SAMPLES - 1));

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sample_cnt <= 32'h0000_0000;
            disp_cnt <= 8'h00;
        end else begin
            sample_cnt <= sample_tick ? 32'h0000_0000 : sample_cnt + 32'h0000_0001;
            if (sample_tick) disp_cnt <= disp_tick ? 8'h00 : disp_cnt + 8'h01;
        end
    end

    // revolution crossing from the sub-revolution carry or borrow
    wire [33:0] sub_sum = {2'b00, sub_acc} + {{2{enc_delta[31]}}, enc_delta};
    wire carry_up = enc_delta_valid && !sub_sum[33] && sub_sum[32];
    wire borrow_dn = enc_delta_valid && sub_sum[33];
    wire [7:0] pole_pairs = (motor_pole_count < 8'h02) ? 8'h01 : {1'b0, motor_pole_count[7:1]};
    wire [7:0] pitch_last = pole_pairs - 8'h01;
    wire lin_wrap_up = carry_up && (pitch_cnt >= pitch_last);
    wire lin_wrap_dn = borrow_dn && (pitch_cnt == 8'h00);
    wire rev_up = linear_select ? lin_wrap_up : carry_up;
    wire rev_dn = linear_select ? lin_wrap_dn : borrow_dn;
    wire [15:0] rev_stepped = rev_up ? rev_acc + 16'h0001
        : (rev_dn ? rev_acc - 16'h0001 : rev_acc);
    wire [7:0] next_pitch = !linear_select ? 8'h00
        : carry_up ? (lin_wrap_up ? 8'h00 : pitch_cnt + 8'h01)
        : borrow_dn ? (lin_wrap_dn ? pitch_last : pitch_cnt - 8'h01)
        : pitch_cnt;

    // marker detection uses the direction of the last nonzero step
    wire marker_rise = marker_in && !marker_prev;
    wire marker_fall = !marker_in && marker_prev;
    wire marker_dir_ok = (marker_rise && !dir_reverse) || (marker_fall && dir_reverse);
    wire marker_event = epa_marker_type(encoder_type_select) && marker_dir_ok;
    wire marker_reset = marker_event && !marker_reset_inhibit;
    wire abs_load = enc_abs_valid && abs_pending
        && epa_absolute_type(encoder_type_select);
    wire [15:0] live_mask = linear_select ? 16'hFFFF : epa_turns_mask(turns_mask_bits);

    // the marker reset drops a step arriving in the same cycle
    wire [15:0] rev_raw = type_change ? 16'h0000
        : abs_load ? enc_abs_position[47:32]
        : marker_reset ? rev_acc
        : rev_stepped;
    wire [15:0] next_rev = rev_raw & live_mask;
    wire [31:0] next_sub = type_change ? 32'h0000_0000
        : abs_load ? enc_abs_position[31:0]
        : marker_reset ? 32'h0000_0000
        : enc_delta_valid ? sub_sum[31:0]
        : sub_acc;
    wire rev_event = (rev_up || rev_dn) && !type_change && !abs_load && !marker_reset;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rev_acc <= 16'h0000;
            sub_acc <= 32'h0000_0000;
            pitch_cnt <= 8'h00;
            abs_pending <= 1'b1;
            dir_reverse <= 1'b0;
            marker_prev <= 1'b0;
        end else begin
            rev_acc <= next_rev;
            sub_acc <= next_sub;
            pitch_cnt <= type_change ? 8'h00 : next_pitch;
            if (abs_load) abs_pending <= 1'b0;
            if (enc_delta_valid && (enc_delta != 32'h0000_0000)) dir_reverse <= enc_delta[31];
            marker_prev <= marker_in;
        end
    end

    // set wins over a clearing write in the same cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            marker_seen_flag <= 1'b0;
        end else if (marker_event) begin
            marker_seen_flag <= 1'b1;
        end else if (flag_wr) begin
            marker_seen_flag <= avs_writedata[0];
        end
    end

    // speed: window sum of steps over one sample, scaled to tenths of rpm, then filtered
    wire [31:0] window_next = window_sum + (enc_delta_valid ? enc_delta : 32'h0000_0000);
    wire signed [63:0] speed_prod = $signed({{32{window_next[31]}}, window_next})
        * $signed(RPM_SCALE);
    wire signed [31:0] speed_lim = 32'(`EPA_SPEED_LIMIT);
    wire signed [31:0] speed_hi = speed_prod[63:32];
    // the product always fits in 64 bits, so only the range bound may clamp a reading
    wire speed_over = speed_hi > speed_lim;
    wire speed_under = speed_hi < -speed_lim;
    wire signed [31:0] speed_raw = speed_prod[63] ? (speed_under || speed_over ? -speed_lim
        : speed_hi) : (speed_over ? speed_lim : speed_hi);
    wire signed [31:0] speed_step = (speed_raw - speed_filt) >>> FILTER_SHIFT;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            window_sum <= 32'h0000_0000;
            speed_filt <= 32'sh0000_0000;
        end else begin
            window_sum <= sample_tick ? 32'h0000_0000 : window_next;
            if (sample_tick) speed_filt <= speed_filt + speed_step;
        end
    end

    // readable copies; the simulated encoder source can step on every clock cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst || type_change) begin
            revolution_count <= 16'h0000;
            coarse_position <= 16'h0000;
            fine_position <= 16'h0000;
            feedback_position <= 32'h0000_0000;
        end else begin
            if (disp_tick) revolution_count <= rev_acc;
            if (disp_tick) coarse_position <= sub_acc[31:16];
            if (disp_tick) fine_position <= sub_acc[15:0];
            if (sample_tick) feedback_position <= sub_acc;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) shaft_speed_rpm <= 32'sh0000_0000;
        else if (disp_tick) shaft_speed_rpm <= speed_filt;
    end

    // interrupts: sticky status, write-one-to-clear, set wins
    wire [`EPA_IRQ_W-1:0] irq_events = {disp_tick, rev_event, marker_event};
    wire [`EPA_IRQ_W-1:0] irq_clear_bits = (wr_low && sel_clear)
        ? avs_writedata[`EPA_IRQ_W-1:0] : '0;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irq_status <= '0;
            irq <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~irq_clear_bits) | irq_events;
            irq <= |(irq_status & irq_enable);
        end
    end

    a_mask_zero_hold:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        (turns_mask_bits == 8'h00 && !linear_select) |=> (rev_acc == 16'h0000))
    else $error("revolution count not held at zero with zero turns mask");

    a_mask_bound:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        !linear_select |=> ((rev_acc & ~$past(epa_turns_mask(turns_mask_bits))) == 16'h0000))
    else $error("revolution count exceeds turns mask");

    a_reverse_wrap:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        (rev_dn && rev_acc == 16'h0000 && !linear_select && !marker_reset && !abs_load
        && !type_change) |=> (rev_acc == $past(live_mask)))
    else $error("reverse step from zero did not wrap to masked maximum");

    a_forward_count:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        (rev_event && rev_up && linear_select) |=> (rev_acc == $past(rev_acc) + 16'h0001))
    else $error("forward crossing did not increment revolutions");

    a_marker_clears:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        marker_reset |=> (sub_acc == 32'h0000_0000) && marker_seen_flag)
    else $error("marker reset did not clear position or set flag");

    a_marker_gate:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        ($rose(marker_seen_flag) && !$past(flag_wr))
        |-> $past(epa_marker_type(encoder_type_select))
        && ($past(marker_in) != $past(marker_in, 2)) && ($past(marker_in) != $past(dir_reverse)))
    else $error("marker flag set without a valid marker edge");

    a_inhibit_keeps:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        (marker_event && marker_reset_inhibit && !type_change && !abs_load && !enc_delta_valid)
        |=> $stable(sub_acc))
    else $error("inhibited marker changed the position");

    a_flag_sticky:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        (marker_seen_flag && !flag_wr) |=> marker_seen_flag)
    else $error("marker flag cleared without a software write");

    a_type_clear:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        type_change |=> (rev_acc == 16'h0000) && (sub_acc == 32'h0000_0000)
        && (revolution_count == 16'h0000) && (coarse_position == 16'h0000))
    else $error("encoder type change did not clear position");

    a_display_hold:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!disp_tick && !type_change) |=> $stable(revolution_count) && $stable(coarse_position))
    else $error("display copy changed between refreshes");

    a_feedback_rate:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!sample_tick && !type_change) |=> $stable(feedback_position))
    else $error("feedback position changed between sample ticks");

    a_speed_range:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        (shaft_speed_rpm <= speed_lim) && (shaft_speed_rpm >= -speed_lim))
    else $error("speed reading outside range");

    a_bus_answer:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        ((avs_read || avs_write) && avs_waitrequest) |-> ##[1:2] !avs_waitrequest)
    else $error("bus request not answered");

    c_marker_reset: cover property (@(posedge sys_clk) disable iff (sys_rst) marker_reset);
    c_reverse_wrap: cover property (@(posedge sys_clk) disable iff (sys_rst)
        rev_dn && rev_acc == 16'h0000 && !linear_select);
    c_display_flag: cover property (@(posedge sys_clk) disable iff (sys_rst)
        disp_tick && marker_seen_flag);
    c_abs_load: cover property (@(posedge sys_clk) disable iff (sys_rst) abs_load);
    c_linear_rev: cover property (@(posedge sys_clk) disable iff (sys_rst)
        rev_up && linear_select);

endmodule : epa_accumulator

// File: hw/epa_defs.svh
`ifndef EPA_DEFS_SVH
`define EPA_DEFS_SVH

// timing
`define EPA_CLK_PERIOD_NS 4
`define EPA_SAMPLE_TIME_NS 250000
`define EPA_SAMPLE_CYCLES (`EPA_SAMPLE_TIME_NS / `EPA_CLK_PERIOD_NS)
`define EPA_DISPLAY_TIME_MS 4
`define EPA_DISPLAY_SAMPLES (`EPA_DISPLAY_TIME_MS * 1000000 / `EPA_SAMPLE_TIME_NS)
`define EPA_NS_PER_MIN 64'h0000_000D_F847_5800

// speed reading, in tenths of rpm
`define EPA_SPEED_MAX_RPM 40000
`define EPA_SPEED_SCALE 10
`define EPA_SPEED_LIMIT (`EPA_SPEED_MAX_RPM * `EPA_SPEED_SCALE)
`define EPA_FILTER_SHIFT 4

// register byte offsets
`define EPA_REG_SPEED 8'h00
`define EPA_REG_REVS 8'h04
`define EPA_REG_COARSE 8'h08
`define EPA_REG_FINE 8'h0C
`define EPA_REG_INHIBIT 8'h10
`define EPA_REG_FLAG 8'h14
`define EPA_REG_TURNS 8'h18
`define EPA_REG_TYPE 8'h1C
`define EPA_REG_LINEAR 8'h20
`define EPA_REG_POLES 8'h24
`define EPA_REG_IRQ_STATUS 8'h28
`define EPA_REG_IRQ_CLEAR 8'h2C
`define EPA_REG_IRQ_ENABLE 8'h30
`define EPA_REG_FEEDBACK 8'h34

// reset values and limits
`define EPA_RST_TURNS 8'h10
`define EPA_RST_POLES 8'h06
`define EPA_TURNS_MAX 8'h10

// interrupt status bits
`define EPA_IRQ_MARKER 0
`define EPA_IRQ_REV 1
`define EPA_IRQ_DISPLAY 2
`define EPA_IRQ_W 3

`endif

// File: hw/epa_pkg.sv
package epa_pkg;

    typedef enum logic [3:0] {
        epa_quadrature_incremental = 4'h0,
        epa_frequency_direction_incremental = 4'h1,
        epa_forward_reverse_incremental = 4'h2,
        epa_quadrature_servo = 4'h3,
        epa_frequency_direction_servo = 4'h4,
        epa_forward_reverse_servo = 4'h5,
        epa_sine_cosine_incremental = 4'h6,
        epa_sine_cosine_servo = 4'h7,
        epa_absolute_comms = 4'h8,
        epa_sine_cosine_absolute = 4'h9
    } epa_enc_type_t;

endpackage : epa_pkg

// File: tb/epa_enc_model.sv
module epa_enc_model (
    input wire logic sys_clk,
    output logic enc_delta_valid,
    output logic [31:0] enc_delta,
    output logic enc_abs_valid,
    output logic [47:0] enc_abs_position,
    output logic marker_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        enc_delta_valid = 1'b0;
        enc_delta = 32'h0;
        enc_abs_valid = 1'b0;
        enc_abs_position = 48'h0;
        marker_in = 1'b0;
    end

    // idle data flips so a stale step never passes for a fresh one
    task automatic move(input logic [31:0] step, input int n);
        repeat (n) begin
            @(posedge sys_clk);
            enc_delta_valid <= 1'b1;
            enc_delta <= step;
        end
        @(posedge sys_clk);
        enc_delta_valid <= 1'b0;
        enc_delta <= ~step;
    endtask : move

    // level held a few cycles so the edge detector sees it
    task automatic mark(input logic lvl);
        @(posedge sys_clk);
        marker_in <= lvl;
        repeat (4) @(posedge sys_clk);
    endtask : mark

    task automatic abs_load(input logic [47:0] pos);
        @(posedge sys_clk);
        enc_abs_valid <= 1'b1;
        enc_abs_position <= pos;
        @(posedge sys_clk);
        enc_abs_valid <= 1'b0;
        enc_abs_position <= ~pos;
    endtask : abs_load
endmodule : epa_enc_model

// File: tb/tb_top.sv
`include "epa_defs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SC = 64;
    localparam int DS = 2;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} epa_row_t;
    logic sys_clk;
    logic sys_rst;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic enc_delta_valid;
    logic [31:0] enc_delta;
    logic enc_abs_valid;
    logic [47:0] enc_abs_position;
    logic marker_in;
    logic [31:0] feedback_position;
    logic irq;
    logic [31:0] q;
    int fail_count;
    int cmp_count;
    // reset values first, then read-back and refused writes
    epa_row_t rows [15] = '{
        '{1'b0, `EPA_REG_INHIBIT, 32'h0, 32'h0}, '{1'b0, `EPA_REG_FLAG, 32'h0, 32'h0},
        '{1'b0, `EPA_REG_TURNS, 32'h0, 32'h10}, '{1'b0, `EPA_REG_TYPE, 32'h0, 32'h0},
        '{1'b0, `EPA_REG_POLES, 32'h0, 32'h6}, '{1'b0, `EPA_REG_IRQ_ENABLE, 32'h0, 32'h0},
        '{1'b0, `EPA_REG_REVS, 32'h0, 32'h0}, '{1'b1, `EPA_REG_INHIBIT, 32'h1, 32'h1},
        '{1'b1, `EPA_REG_INHIBIT, 32'h0, 32'h0}, '{1'b1, `EPA_REG_POLES, 32'h2, 32'h2},
        '{1'b1, `EPA_REG_IRQ_ENABLE, 32'h7, 32'h7}, '{1'b1, `EPA_REG_IRQ_CLEAR, 32'h7, 32'h0},
        '{1'b1, `EPA_REG_SPEED, 32'hFFFF, 32'h0}, '{1'b1, 8'h40, 32'h5, 32'h0},
        '{1'b1, `EPA_REG_IRQ_ENABLE, 32'h0, 32'h0}};

    epa_accumulator #(.SAMPLE_CYCLES(SC), .DISPLAY_SAMPLES(DS)) dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .enc_delta_valid(enc_delta_valid),
        .enc_delta(enc_delta), .enc_abs_valid(enc_abs_valid),
        .enc_abs_position(enc_abs_position), .marker_in(marker_in),
        .feedback_position(feedback_position), .irq(irq));

    epa_enc_model u_enc (
        .sys_clk(sys_clk), .enc_delta_valid(enc_delta_valid), .enc_delta(enc_delta),
        .enc_abs_valid(enc_abs_valid), .enc_abs_position(enc_abs_position),
        .marker_in(marker_in));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] rdata);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 20) check("waitrequest", 32'h1, 32'h0);
    endtask : bus

    task automatic w(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, 4'hF, x);
    endtask : w

    task automatic r(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, 4'hF, x);
        check(name, x, exp);
    endtask : r

    // two display periods plus margin, so every reading has refreshed at least once
    task automatic settle();
        repeat (2 * SC * DS + 8) @(posedge sys_clk);
    endtask : settle

    task automatic pulse();
        u_enc.mark(1'b1);
        u_enc.mark(1'b0);
    endtask : pulse

    initial begin
        sys_rst = 1'b1;
        avs_address = 8'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        fail_count = 0;
        cmp_count = 0;
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr) w(rows[i].a, rows[i].d);
            r("row", rows[i].a, rows[i].e);
        end
        u_enc.move(32'h1234_5678, 1);
        settle();
        r("coarse", `EPA_REG_COARSE, 32'h1234);
        r("fine", `EPA_REG_FINE, 32'h5678);
        check("feedback", feedback_position, 32'h1234_5678);
        w(`EPA_REG_TYPE, 32'h1);
        r("revs clr", `EPA_REG_REVS, 32'h0);
        r("coarse clr", `EPA_REG_COARSE, 32'h0);
        r("fine clr", `EPA_REG_FINE, 32'h0);
        u_enc.move(32'h4000_0000, 8);
        settle();
        r("revs up", `EPA_REG_REVS, 32'h2);
        u_enc.move(32'hC000_0000, 12);
        settle();
        r("revs roll", `EPA_REG_REVS, 32'hFFFF);
        w(`EPA_REG_TYPE, 32'h0);
        w(`EPA_REG_TURNS, 32'h2);
        u_enc.move(32'h4000_0000, 20);
        settle();
        r("revs mask", `EPA_REG_REVS, 32'h1);
        u_enc.move(32'hC000_0000, 8);
        settle();
        r("revs rev wrap", `EPA_REG_REVS, 32'h3);
        w(`EPA_REG_TURNS, 32'h0);
        u_enc.move(32'h4000_0000, 4);
        settle();
        r("revs held", `EPA_REG_REVS, 32'h0);
        w(`EPA_REG_TURNS, 32'h0014);
        u_enc.move(32'hC000_0000, 4);
        settle();
        r("revs big mask", `EPA_REG_REVS, 32'hFFFF);
        w(`EPA_REG_IRQ_ENABLE, 32'h1);
        u_enc.move(32'h0100_0000, 1);
        pulse();
        settle();
        r("flag", `EPA_REG_FLAG, 32'h1);
        r("coarse mark", `EPA_REG_COARSE, 32'h0);
        r("fine mark", `EPA_REG_FINE, 32'h0);
        check("irq set", {31'h0, irq}, 32'h1);
        w(`EPA_REG_IRQ_CLEAR, 32'h1);
        repeat (2) @(posedge sys_clk);
        check("irq clr", {31'h0, irq}, 32'h0);
        w(`EPA_REG_FLAG, 32'h0);
        r("flag clr", `EPA_REG_FLAG, 32'h0);
        w(`EPA_REG_IRQ_ENABLE, 32'h0);
        w(`EPA_REG_INHIBIT, 32'h1);
        u_enc.move(32'h0100_0000, 1);
        pulse();
        settle();
        r("flag inh", `EPA_REG_FLAG, 32'h1);
        r("coarse inh", `EPA_REG_COARSE, 32'h0100);
        check("irq masked", {31'h0, irq}, 32'h0);
        w(`EPA_REG_IRQ_ENABLE, 32'h1);
        repeat (2) @(posedge sys_clk);
        check("irq unmask", {31'h0, irq}, 32'h1);
        w(`EPA_REG_INHIBIT, 32'h0);
        w(`EPA_REG_FLAG, 32'h0);
        u_enc.move(32'hFF80_0000, 1);
        u_enc.mark(1'b1);
        r("flag rev rise", `EPA_REG_FLAG, 32'h0);
        u_enc.mark(1'b0);
        settle();
        r("flag rev fall", `EPA_REG_FLAG, 32'h1);
        r("coarse rev", `EPA_REG_COARSE, 32'h0);
        w(`EPA_REG_TYPE, 32'(epa_pkg::epa_sine_cosine_incremental));
        w(`EPA_REG_FLAG, 32'h0);
        u_enc.move(32'h0100_0000, 1);
        pulse();
        r("flag no mark", `EPA_REG_FLAG, 32'h0);
        // a steady 4096 per cycle is 143051 tenths of rpm; the filter only approaches it
        u_enc.move(32'h0000_1000, 1000);
        bus(1'b0, `EPA_REG_SPEED, 32'h0, 4'hF, q);
        check("speed", 32'(($signed(q) > 0) && ($signed(q) <= 143051)), 32'h1);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        r("turns rst", `EPA_REG_TURNS, 32'h10);
        w(`EPA_REG_TYPE, 32'(epa_pkg::epa_absolute_comms));
        u_enc.abs_load(48'h0003_8000_0000);
        settle();
        r("revs abs", `EPA_REG_REVS, 32'h3);
        r("coarse abs", `EPA_REG_COARSE, 32'h8000);
        bus(1'b1, `EPA_REG_INHIBIT, 32'h1, 4'h0, q);
        r("no byte0", `EPA_REG_INHIBIT, 32'h0);
        // linear: six pole pitches make two revolutions and the turns mask is ignored
        w(`EPA_REG_TYPE, 32'h0);
        w(`EPA_REG_TURNS, 32'h1);
        w(`EPA_REG_LINEAR, 32'h1);
        u_enc.move(32'h4000_0000, 24);
        settle();
        r("revs linear", `EPA_REG_REVS, 32'h2);
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        wrap_up();
    end
endmodule : tb_top
